// >>> verilog/psel_consts.vh
// Constants for the settings profile selector: offsets, fields, resets
`ifndef PSEL_CONSTS_VH
`define PSEL_CONSTS_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define PSEL_NPROF          8
`define PSEL_IDX_W          3
`define PSEL_ADDR_W         8

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PSEL_OFS_CTRL       8'h00
`define PSEL_OFS_FORCE      8'h04
`define PSEL_OFS_REMOTE     8'h08
`define PSEL_OFS_STATUS     8'h0C
`define PSEL_OFS_FAIL       8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSEL_CTRL_USED_LSB  0
`define PSEL_CTRL_USED_MSB  2
`define PSEL_CTRL_OVR_BIT   4
`define PSEL_SEL_MSB        3
`define PSEL_ST_CFG_LSB     8
`define PSEL_ST_IDLE_BIT    16
`define PSEL_ST_HOLD_BIT    17
`define PSEL_ST_OVR_BIT     18
`define PSEL_FAIL_UNCFG_BIT 0
`define PSEL_FAIL_PRIO_BIT  1
`define PSEL_FAIL_FORCE_BIT 2

// ----------------------------------------------------------------
// Reset values and selector codes
// ----------------------------------------------------------------
`define PSEL_RST_USED       3'h0
`define PSEL_RST_ACTIVE     3'h0
`define PSEL_SEL_NONE       4'h0
`define PSEL_SEL_MAX        4'h8

`endif

// >>> verilog/psel_sync_edge.v
// Two-flop synchroniser with rising edge detect for a group of pins
`timescale 1ns/10ps
module psel_sync_edge #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         mclk,
    input  wire         sys_rst,
    // Pins in
    input  wire [W-1:0] pin_in,
    // Synchronised level and rising edge
    output wire [W-1:0] level,
    output wire [W-1:0] rise
);
    reg [W-1:0] meta;
    reg [W-1:0] sync;
    reg [W-1:0] last;

    // First stage feeds only the second; edge uses stages two and three
    always @(posedge mclk) begin
        if (sys_rst) begin
            meta <= {W{1'b0}};
            sync <= {W{1'b0}};
            last <= {W{1'b0}};
        end else begin
            meta <= pin_in;
            sync <= meta;
            last <= sync;
        end
    end

    assign level = sync;
    assign rise  = sync & ~last;
endmodule

// >>> verilog/psel_prienc.v
// Priority encoder, bit 0 is the highest priority
`timescale 1ns/10ps
module psel_prienc #(
    parameter W  = 8,
    parameter IW = 3
) (
    // Request vector in
    input  wire [W-1:0]  vec,
    // Winner out
    output reg           valid,
    output reg  [IW-1:0] idx
);
    integer i;

    // Scan from lowest priority up so the lowest set bit wins last
    always @* begin
        valid = 1'b0;
        idx   = {IW{1'b0}};
        for (i = W - 1; i >= 0; i = i - 1) begin
            if (vec[i]) begin
                valid = 1'b1;
                idx   = i[IW-1:0];
            end
        end
    end
endmodule

// >>> verilog/psel_selector.v
// Settings profile selector: request resolution, override and registers
//
// Overview of operation
// - Eight profiles, exactly one always active
// - Reset: profile one only, selection idle
// - Several configured: requests decide active profile
// - Every profile has its own request input
// - Request may be pulse or static level
// - Fixed priority, profile one highest wins
// - Two static levels: higher priority active
// - Pulse choice stays until another request
// - Static level blocks lower requests; eight blocks none
// - Override enable suspends automatic selection
// - Forced change needs configured target and override
// - Force selector: none or one to eight
// - Forced choice acts like pulse, persists
// - Static levels resume control once override clears
// - Contiguous configured range; new profiles load defaults
// - Remote request refused below held profile
// - Active profile reported as one to eight
// - Fail flag for unconfigured profile request
// - Fail flag for priority refused request
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
`include "psel_consts.vh"
module psel_selector (
    // Clock and reset
    input  wire        mclk,
    input  wire        sys_rst,
    // Profile request pins, bit 0 is profile_one
    input  wire [7:0]  req_pin,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Active profile, code 0 is profile_one
    output reg  [2:0]  active_profile,
    output reg  [7:0]  profile_active,
    // Failure indications, sticky
    output reg         fail_unconfigured,
    output reg         fail_priority,
    output reg         fail_force,
    // One-cycle strobe: load default values into newly configured profiles
    output reg  [7:0]  profile_defaults_load
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg  [2:0] used_last;
    reg        override_enable;
    reg  [3:0] force_sel;
    reg  [3:0] remote_sel;
    reg        force_evt;
    reg        remote_evt;
    reg  [7:0] prev_cfg;

    wire [7:0] req_level;
    wire [7:0] req_rise;
    wire       hold_valid;
    wire [2:0] hold_idx;
    wire       win_valid;
    wire [2:0] win_idx;

    reg  [7:0] cfg_mask;
    reg  [7:0] lower_mask;
    reg  [7:0] remote_hot;
    reg  [7:0] cand;
    reg  [2:0] remote_idx;
    reg  [2:0] force_idx;
    reg        remote_cfg;
    reg        remote_low;
    reg        remote_ok;
    reg        force_ok;
    reg        set_uncfg;
    reg        set_prio;
    reg        set_force;
    reg  [2:0] next_active;
    reg  [7:0] next_onehot;
    reg  [31:0] next_rdata;

    wire       wr_ctrl;
    wire       wr_force;
    wire       wr_remote;
    wire       wr_fail;
    wire       sel_legal;

    integer i;
    integer j;

    // ----------------------------------------------------------------
    // Request inputs
    // ----------------------------------------------------------------

    // Pins come from outside logic and are synchronised before use
    psel_sync_edge #(
        .W (8)
    ) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pin_in  (req_pin),
        .level   (req_level),
        .rise    (req_rise)
    );

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------

    // Plain strobes; the slave never stalls
    assign wr_ctrl   = reg_wr && (reg_addr == `PSEL_OFS_CTRL);
    assign wr_force  = reg_wr && (reg_addr == `PSEL_OFS_FORCE);
    assign wr_remote = reg_wr && (reg_addr == `PSEL_OFS_REMOTE);
    assign wr_fail   = reg_wr && (reg_addr == `PSEL_OFS_FAIL);

    // Selector codes above eight are dropped without effect
    assign sel_legal = (reg_wdata[`PSEL_SEL_MSB:0] <= `PSEL_SEL_MAX);

    // Software settings and one-cycle request events
    always @(posedge mclk) begin
        if (sys_rst) begin
            used_last       <= `PSEL_RST_USED;
            override_enable <= 1'b0;
            force_sel       <= `PSEL_SEL_NONE;
            remote_sel      <= `PSEL_SEL_NONE;
            force_evt       <= 1'b0;
            remote_evt      <= 1'b0;
        end else begin
            force_evt  <= 1'b0;
            remote_evt <= 1'b0;
            if (wr_ctrl) begin
                used_last       <= reg_wdata[`PSEL_CTRL_USED_MSB:`PSEL_CTRL_USED_LSB];
                override_enable <= reg_wdata[`PSEL_CTRL_OVR_BIT];
            end
            if (wr_force && sel_legal) begin
                force_sel <= reg_wdata[`PSEL_SEL_MSB:0];
                force_evt <= (reg_wdata[`PSEL_SEL_MSB:0] != `PSEL_SEL_NONE);
            end
            if (wr_remote && sel_legal) begin
                remote_sel <= reg_wdata[`PSEL_SEL_MSB:0];
                remote_evt <= (reg_wdata[`PSEL_SEL_MSB:0] != `PSEL_SEL_NONE);
            end
        end
    end

    // ----------------------------------------------------------------
    // Configured range
    // ----------------------------------------------------------------

    // Contiguous range from profile_one up to used_last
    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            cfg_mask[i] = (i[2:0] <= used_last);
        end
    end

    // Highest priority static level among configured profiles holds
    psel_prienc #(
        .W  (8),
        .IW (3)
    ) u_hold (
        .vec   (req_level & cfg_mask),
        .valid (hold_valid),
        .idx   (hold_idx)
    );

    // ----------------------------------------------------------------
    // Remote and forced targets
    // ----------------------------------------------------------------

    // Codes 1..8 map to index 0..7; events only fire for non-zero codes
    always @* begin
        remote_idx = remote_sel[2:0] - 3'h1;
        force_idx  = force_sel[2:0] - 3'h1;
        remote_cfg = cfg_mask[remote_idx];
        // Lower priority than a held profile cannot be taken remotely
        remote_low = hold_valid && (remote_idx > hold_idx);
        remote_ok  = remote_evt && !override_enable && remote_cfg && !remote_low;
        force_ok   = force_evt && override_enable && cfg_mask[force_idx];
        remote_hot = 8'h00;
        if (remote_ok) begin
            remote_hot[remote_idx] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Candidate requests
    // ----------------------------------------------------------------

    // Pins request every cycle they are high, pulses included, since rise is a subset of level;
    // unconfigured inputs are masked out and so never move the profile
    always @* begin
        cand = ((req_rise | req_level) & cfg_mask) | remote_hot;
    end

    // One encoder resolves all candidates, profile_one first
    psel_prienc #(
        .W  (8),
        .IW (3)
    ) u_win (
        .vec   (cand),
        .valid (win_valid),
        .idx   (win_idx)
    );

    // ----------------------------------------------------------------
    // Next active profile
    // ----------------------------------------------------------------

    // Priority: idle, shrink fallback, override, automatic, keep
    always @* begin
        next_active = active_profile;
        if (used_last == 3'h0) begin
            next_active = 3'h0;
        end else if (!cfg_mask[active_profile]) begin
            // Active profile dropped out of range: fall back to profile_one
            next_active = 3'h0;
        end else if (override_enable) begin
            if (force_ok) begin
                next_active = force_idx;
            end
        end else if (win_valid) begin
            // Level requests win again as soon as override clears
            next_active = win_idx;
        end
        next_onehot = 8'h00;
        next_onehot[next_active] = 1'b1;
    end

    // ----------------------------------------------------------------
    // Failure causes
    // ----------------------------------------------------------------

    // Pulses below a held profile are refused, profile_eight holds none
    always @* begin
        for (j = 0; j < 8; j = j + 1) begin
            lower_mask[j] = hold_valid && (j[2:0] > hold_idx);
        end
    end

    // Refused requests leave a sticky flag behind, except pin and remote requests while override is set
    always @* begin
        set_uncfg = 1'b0;
        set_prio  = 1'b0;
        set_force = 1'b0;
        if (!override_enable) begin
            if (|(req_rise & ~cfg_mask)) begin
                set_uncfg = 1'b1;
            end
            if (remote_evt && !remote_cfg) begin
                set_uncfg = 1'b1;
            end
            if (|(req_rise & cfg_mask & lower_mask)) begin
                set_prio = 1'b1;
            end
            if (remote_evt && remote_cfg && remote_low) begin
                set_prio = 1'b1;
            end
            if (force_evt) begin
                set_force = 1'b1;
            end
        end else if (force_evt && !cfg_mask[force_idx]) begin
            set_uncfg = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------

    // Active profile held encoded, plus its one-hot copy
    always @(posedge mclk) begin
        if (sys_rst) begin
            active_profile <= `PSEL_RST_ACTIVE;
            profile_active <= 8'h01;
        end else begin
            active_profile <= next_active;
            profile_active <= next_onehot;
        end
    end

    // Sticky failures; a new cause beats a clear in the same cycle
    always @(posedge mclk) begin
        if (sys_rst) begin
            fail_unconfigured <= 1'b0;
            fail_priority     <= 1'b0;
            fail_force        <= 1'b0;
        end else begin
            fail_unconfigured <= set_uncfg |
                (fail_unconfigured & ~(wr_fail & reg_wdata[`PSEL_FAIL_UNCFG_BIT]));
            fail_priority     <= set_prio |
                (fail_priority & ~(wr_fail & reg_wdata[`PSEL_FAIL_PRIO_BIT]));
            fail_force        <= set_force |
                (fail_force & ~(wr_fail & reg_wdata[`PSEL_FAIL_FORCE_BIT]));
        end
    end

    // Newly configured profiles get a one-cycle default load strobe
    always @(posedge mclk) begin
        if (sys_rst) begin
            prev_cfg              <= 8'h01;
            profile_defaults_load <= 8'h00;
        end else begin
            prev_cfg              <= cfg_mask;
            profile_defaults_load <= cfg_mask & ~prev_cfg;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Read data stand only in the cycle after the strobe
    always @* begin
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `PSEL_OFS_CTRL: begin
                    next_rdata[`PSEL_CTRL_USED_MSB:`PSEL_CTRL_USED_LSB] = used_last;
                    next_rdata[`PSEL_CTRL_OVR_BIT] = override_enable;
                end
                `PSEL_OFS_FORCE: begin
                    next_rdata[`PSEL_SEL_MSB:0] = force_sel;
                end
                `PSEL_OFS_REMOTE: begin
                    next_rdata[`PSEL_SEL_MSB:0] = remote_sel;
                end
                `PSEL_OFS_STATUS: begin
                    // Reported as 1..8 for software
                    next_rdata[`PSEL_SEL_MSB:0] = {1'b0, active_profile} + 4'h1;
                    next_rdata[`PSEL_ST_CFG_LSB+7:`PSEL_ST_CFG_LSB] = cfg_mask;
                    next_rdata[`PSEL_ST_IDLE_BIT] = (used_last == 3'h0);
                    next_rdata[`PSEL_ST_HOLD_BIT] = hold_valid;
                    next_rdata[`PSEL_ST_OVR_BIT]  = override_enable;
                end
                `PSEL_OFS_FAIL: begin
                    next_rdata[`PSEL_FAIL_UNCFG_BIT] = fail_unconfigured;
                    next_rdata[`PSEL_FAIL_PRIO_BIT]  = fail_priority;
                    next_rdata[`PSEL_FAIL_FORCE_BIT] = fail_force;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Registered read data, zero when no read was made
    always @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// >>> bench/psel_req_model.sv
// Request pin model: static levels and stretched pulses on the profile pins
`timescale 1ns/10ps
module psel_req_model (
    // Clock
    input  wire       mclk,
    // Commands from the bench
    input  wire [7:0] level,
    input  wire [7:0] pulse_go,
    // Pins to the selector
    output wire [7:0] req_pin
);
    // Pulse tails keep a short request wide enough for the two-flop sampler
    logic [7:0] tail_a = 8'h00;
    logic [7:0] tail_b = 8'h00;
    always @(posedge mclk) begin
        tail_a <= pulse_go;
        tail_b <= tail_a;
    end
    // Each pin carries its own level or pulse, independent of the others
    assign req_pin = level | pulse_go | tail_a | tail_b;
endmodule

// >>> bench/psel_selector_props.sv
// Assertion checker for the settings profile selector ports
`timescale 1ns/10ps
module psel_selector_props (
    // Clock and reset
    input wire        mclk,
    input wire        sys_rst,
    // Requests and register port
    input wire [7:0]  req_pin,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // Results
    input wire [2:0]  active_profile,
    input wire [7:0]  profile_active,
    input wire        fail_unconfigured,
    input wire        fail_priority,
    input wire        fail_force,
    input wire [7:0]  profile_defaults_load
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Cycles since the last pin change or register write
    logic [3:0] quiet_cnt;
    logic [7:0] pin_prev;
    logic       ctrl_wr_d;
    logic       ctrl_wr_dd;
    // Load strobe shows one edge after the control write is taken
    always @(posedge mclk) begin
        pin_prev <= req_pin;
        ctrl_wr_d <= reg_wr && (reg_addr == 8'h00);
        ctrl_wr_dd <= ctrl_wr_d;
        if (sys_rst || reg_wr || (req_pin != pin_prev)) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hF) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end
    // Exactly one profile, and the one-hot agrees with the code
    property p_onehot;
        profile_active == (8'h01 << active_profile);
    endproperty
    a_onehot: assert property (p_onehot) else $error("one-hot and code disagree");
    // Reset leaves profile one with no failures
    property p_rst;
        disable iff (1'b0) sys_rst |=> active_profile == 3'h0 && profile_active == 8'h01
            && !fail_unconfigured && !fail_priority && !fail_force;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    // Read data is zero outside the answer cycle
    property p_rdata_zero;
        !reg_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data not zero");
    // Status reports the active profile as one to eight
    property p_status_read;
        reg_rd && reg_addr == 8'h0C |=> reg_rdata[3:0] == {1'b0, $past(active_profile)} + 4'h1;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status profile wrong");
    // Default load strobe follows a range write and lasts one cycle
    property p_defaults;
        profile_defaults_load != 8'h00 |-> ctrl_wr_dd ##1 profile_defaults_load == 8'h00;
    endproperty
    a_defaults: assert property (p_defaults) else $error("default load strobe wrong");
    // Unconfigured and priority failure flags stay until software clears them
    property p_unc_sticky;
        fail_unconfigured && !(reg_wr && reg_addr == 8'h10 && reg_wdata[0]) |=> fail_unconfigured;
    endproperty
    a_unc_sticky: assert property (p_unc_sticky) else $error("unconfigured flag lost");
    property p_pri_sticky;
        fail_priority && !(reg_wr && reg_addr == 8'h10 && reg_wdata[1]) |=> fail_priority;
    endproperty
    a_pri_sticky: assert property (p_pri_sticky) else $error("priority flag lost");
    // With no new request the choice is held, so a pulse choice persists
    property p_hold;
        quiet_cnt >= 4'h6 |-> $stable(active_profile);
    endproperty
    a_hold: assert property (p_hold) else $error("active profile moved without cause");
    // Main scenarios reached
    c_pri: cover property (fail_priority);
    c_load: cover property (profile_defaults_load != 8'h00);
    c_last: cover property (active_profile == 3'h7);
endmodule

bind psel_selector psel_selector_props u_props (
    .mclk(mclk), .sys_rst(sys_rst), .req_pin(req_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .active_profile(active_profile), .profile_active(profile_active),
    .fail_unconfigured(fail_unconfigured), .fail_priority(fail_priority),
    .fail_force(fail_force), .profile_defaults_load(profile_defaults_load)
);

// >>> bench/testbench.sv
// Self-checking testbench for the settings profile selector
`timescale 1ns/10ps
`include "psel_consts.vh"
module testbench;
    // Clock, reset and design inputs
    logic        mclk;
    logic        sys_rst;
    logic [7:0]  req_level;
    logic [7:0]  req_pulse;
    wire  [7:0]  req_pin;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    // Design outputs
    wire  [31:0] reg_rdata;
    wire  [2:0]  active_profile;
    wire  [7:0]  profile_active;
    wire         fail_unconfigured;
    wire         fail_priority;
    wire         fail_force;
    wire  [7:0]  profile_defaults_load;
    // Bookkeeping and the level table with the code each row should leave
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [31:0] rd_val;
    logic [7:0]  row_level [7] = '{8'h80, 8'h00, 8'h30, 8'h20, 8'h01, 8'h81, 8'h00};
    logic [2:0]  row_code [7] = '{3'h7, 3'h7, 3'h4, 3'h5, 3'h0, 3'h0, 3'h0};

    psel_req_model u_model (.mclk(mclk), .level(req_level), .pulse_go(req_pulse),
                            .req_pin(req_pin));
    psel_selector dut (
        .mclk(mclk), .sys_rst(sys_rst), .req_pin(req_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .active_profile(active_profile), .profile_active(profile_active),
        .fail_unconfigured(fail_unconfigured), .fail_priority(fail_priority),
        .fail_force(fail_force), .profile_defaults_load(profile_defaults_load)
    );

    // Clock at 4 ns
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("Checks run: %0d, mismatches: %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Active code and its one-hot copy checked together
    task automatic chk_prof(input logic [2:0] exp);
        tests_run++;
        if (active_profile !== exp || profile_active !== (8'h01 << exp)) begin
            errors++;
            $display("[FAIL] active_profile expected %h seen %h", exp, active_profile);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic pulse(input logic [7:0] b);
        @(posedge mclk);
        req_pulse <= b;
        @(posedge mclk);
        req_pulse <= 8'h00;
    endtask
    task automatic set_level(input logic [7:0] v);
        @(posedge mclk);
        req_level <= v;
    endtask

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            print_verdict;
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        req_level = 8'h00;
        req_pulse = 8'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        #1 chk_prof(3'h0);
        reg_read(`PSEL_OFS_STATUS);
        chk_word("status", 32'h0001_0101, rd_val);
        // Single profile: requests ignored, unconfigured one flagged
        pulse(8'h08);
        wait_cyc(6);
        chk_prof(3'h0);
        chk_word("fail_unconfigured", 32'h0000_0001, {31'h0, fail_unconfigured});
        reg_write(`PSEL_OFS_FAIL, 32'h0000_0007);
        reg_read(`PSEL_OFS_FAIL);
        chk_word("fail reg", 32'h0000_0000, rd_val);
        // All eight configured; new ones get defaults
        reg_write(`PSEL_OFS_CTRL, 32'h0000_0007);
        wait_cyc(1);
        chk_word("defaults", 32'h0000_00FE, {24'h0, profile_defaults_load});
        // Level table
        for (int i = 0; i < 7; i++) begin
            set_level(row_level[i]);
            wait_cyc(6);
            chk_prof(row_code[i]);
        end
        reg_write(`PSEL_OFS_FAIL, 32'h0000_0007);
        // Pulses latch, and a lower pulse moves when nothing is held
        pulse(8'h20);
        wait_cyc(6);
        chk_prof(3'h5);
        pulse(8'h40);
        wait_cyc(6);
        chk_prof(3'h6);
        pulse(8'h10);
        wait_cyc(1);
        chk_prof(3'h6);
        wait_cyc(1);
        chk_prof(3'h4);
        // Held level refuses a lower remote request
        set_level(8'h04);
        wait_cyc(6);
        chk_prof(3'h2);
        reg_read(`PSEL_OFS_STATUS);
        chk_word("status hold", 32'h0000_0001, {31'h0, rd_val[17]});
        reg_write(`PSEL_OFS_REMOTE, 32'h0000_0004);
        wait_cyc(3);
        chk_prof(3'h2);
        chk_word("fail_priority", 32'h0000_0001, {31'h0, fail_priority});
        set_level(8'h00);
        reg_write(`PSEL_OFS_FAIL, 32'h0000_0007);
        reg_write(`PSEL_OFS_REMOTE, 32'h0000_0008);
        wait_cyc(2);
        chk_prof(3'h7);
        // Override suspends the held level; clearing it hands control back
        set_level(8'h01);
        wait_cyc(6);
        chk_prof(3'h0);
        reg_write(`PSEL_OFS_CTRL, 32'h0000_0017);
        reg_write(`PSEL_OFS_FORCE, 32'h0000_0006);
        wait_cyc(2);
        chk_prof(3'h5);
        reg_read(`PSEL_OFS_STATUS);
        chk_word("status override", 32'h0000_0001, {31'h0, rd_val[18]});
        reg_write(`PSEL_OFS_CTRL, 32'h0000_0007);
        wait_cyc(2);
        chk_prof(3'h0);
        // Forced choice persists after the override is cleared
        set_level(8'h00);
        reg_write(`PSEL_OFS_CTRL, 32'h0000_0017);
        reg_write(`PSEL_OFS_FORCE, 32'h0000_0003);
        reg_write(`PSEL_OFS_CTRL, 32'h0000_0007);
        wait_cyc(6);
        chk_prof(3'h2);
        reg_write(`PSEL_OFS_FORCE, 32'h0000_0005);
        wait_cyc(2);
        chk_prof(3'h2);
        chk_word("fail_force", 32'h0000_0001, {31'h0, fail_force});
        // Codes above eight are dropped and leave the stored choice alone
        reg_write(`PSEL_OFS_FORCE, 32'h0000_0009);
        reg_read(`PSEL_OFS_FORCE);
        chk_word("force code", 32'h0000_0005, rd_val);
        // Shrunk range falls back; requests beyond it are refused
        reg_write(`PSEL_OFS_FAIL, 32'h0000_0007);
        reg_write(`PSEL_OFS_CTRL, 32'h0000_0001);
        wait_cyc(2);
        chk_prof(3'h0);
        pulse(8'h10);
        wait_cyc(6);
        chk_prof(3'h0);
        chk_word("fail_unconfigured", 32'h0000_0001, {31'h0, fail_unconfigured});
        pulse(8'h02);
        wait_cyc(6);
        chk_prof(3'h1);
        reg_read(8'h20);
        chk_word("unmapped read", 32'h0000_0000, rd_val);
        print_verdict;
    end
endmodule
